// [src/fcs_consts.vh]
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH

// ==========================================================
// Register offsets
`define FCS_OFS_PIN_DIR 8'h08
`define FCS_OFS_DIG_MASK 8'h0b
`define FCS_OFS_SPECIAL_FUNC 8'h0c
`define FCS_OFS_ERROR_CFG 8'h0d
`define FCS_OFS_TEST_CAL 8'h0e
`define FCS_OFS_EXCITATION 8'h0f
`define FCS_OFS_CAL_TRIGGER 8'h2a
`define FCS_OFS_STATUS 8'h30
`define FCS_OFS_CLOCK_CFG 8'h31
`define FCS_OFS_SELECTOR 8'h32
`define FCS_OFS_TEST_SWITCH 8'h33

// ==========================================================
// Writable masks
`define FCS_WMASK_PIN_DIR 8'h7f
`define FCS_WMASK_DIG_MASK 8'h03
`define FCS_WMASK_SPECIAL_FUNC 8'h3f
`define FCS_WMASK_ERROR_CFG 8'h8f
`define FCS_WMASK_TEST_CAL 8'hff
`define FCS_WMASK_EXCITATION 8'hcf
`define FCS_WMASK_CLOCK_CFG 8'h0f
`define FCS_WMASK_SELECTOR 8'h07
`define FCS_WMASK_TEST_SWITCH 8'h03

// ==========================================================
// Reset values
`define FCS_RST_PIN_DIR 8'h00
`define FCS_RST_DIG_MASK 8'h00
`define FCS_RST_SPECIAL_FUNC 8'h00
`define FCS_RST_ERROR_CFG 8'h04
`define FCS_RST_TEST_CAL 8'h00
`define FCS_RST_EXCITATION 8'h00
`define FCS_RST_CLOCK_CFG 8'h04
`define FCS_RST_SELECTOR 8'h00
`define FCS_RST_TEST_SWITCH 8'h00

// ==========================================================
// Field positions
`define FCS_SF_CLK_OUT 5
`define FCS_SF_EXT_CLK 4
`define FCS_SF_FAULT_OUT 3
`define FCS_SF_BUSY_OUT 2
`define FCS_EC_LATCH_DIS 7
`define FCS_TC_GAIN_UP 7
`define FCS_TC_CAL_FULL 6
`define FCS_CLK_OUT_SEL 3
`define FCS_EX_CONNECT 6
`define FCS_SEL_GAIN_LO 2

// ==========================================================
// Diagnostic source codes on the output side
`define FCS_DIAG_AG_AG 3'h0
`define FCS_DIAG_DG_AG 3'h1
`define FCS_DIAG_AG_DG 3'h2
`define FCS_DIAG_DG_DG 3'h3
`define FCS_DIAG_POS20 3'h4
`define FCS_DIAG_NEG20 3'h5
`define FCS_DIAG_NONE 3'h7

// Scale gain codes: 1, 1.25, 1.375
`define FCS_GAIN_X1 2'h0
`define FCS_GAIN_X1P25 2'h1
`define FCS_GAIN_X1P375 2'h2

// ==========================================================
// Timing
`define FCS_MCLK_HZ 40'd200000000
`define FCS_CAL_P1_S 40'd33
`define FCS_CAL_P2_S 40'd132
`define FCS_CAL_P3_S 40'd495
`define FCS_INT_CLK_HZ 32'd1000000
`define FCS_INT_HALF_CYC (32'd200000000 / (32'd2 * `FCS_INT_CLK_HZ))
`define FCS_CAL_QUICK_CYC 13'd1000
`define FCS_CAL_FULL_CYC 13'd4000

`endif

// [src/fcs_flag_filter.v]
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.vh"

module fcs_flag_filter (
   input wire mclk,
   input wire rst_n,
   input wire err_cond,
   input wire mask,
   input wire latch_dis,
   input wire [6:0] delay_cyc,
   input wire clear,
   output reg flag_q
);

   reg [6:0] cnt_q;

   // ==========================================================
   // Flag state; masking wins over everything but reset
   always @(posedge mclk) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
         cnt_q <= 7'h00;
      end else if (mask) begin
         flag_q <= 1'b0;
         cnt_q <= 7'h00;
      end else if (!latch_dis) begin
         // Set wins over a clear in the same cycle
         flag_q <= err_cond | (flag_q & ~clear);
         cnt_q <= 7'h00;
      end else if (!err_cond) begin
         flag_q <= 1'b0;
         cnt_q <= 7'h00;
      end else if (cnt_q >= delay_cyc) begin
         flag_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

endmodule
`default_nettype wire

// [src/fcs_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.vh"

module fcs_regs #(
   parameter [39:0] SCHED_P1_CYC = `FCS_CAL_P1_S * `FCS_MCLK_HZ,
   parameter [39:0] SCHED_P2_CYC = `FCS_CAL_P2_S * `FCS_MCLK_HZ,
   parameter [39:0] SCHED_P3_CYC = `FCS_CAL_P3_S * `FCS_MCLK_HZ
) (
   input wire mclk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_q,
   input wire memmap_checksum_fault,
   input wire rom_checksum_fault,
   input wire [4:0] gp_in,
   output reg [4:0] gp_out_q,
   output reg [4:0] gp_oe_q,
   output reg ext_clk_mode_q,
   output reg ext_tick_q,
   output reg [1:0] err_flags_q,
   output reg cal_busy_q,
   output reg cal_full_q,
   output reg inputs_connected_q,
   output reg [1:0] scale_gain_q,
   output reg [2:0] diag_src_q,
   output reg diag_connect_q,
   output reg excitation_connect_q,
   output reg [3:0] excitation_level_q
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // ==========================================================
   // Persistence code to cycle count
   function [6:0] delay_of;
      input [3:0] code;
      begin
         case (code)
            4'h9: delay_of = 7'd12;
            4'ha: delay_of = 7'd16;
            4'hb: delay_of = 7'd24;
            4'hc: delay_of = 7'd32;
            4'hd: delay_of = 7'd48;
            4'he: delay_of = 7'd64;
            4'hf: delay_of = 7'd127;
            default: delay_of = {3'h0, code};
         endcase
      end
   endfunction

   // Write with reserved bits kept at zero
   function [7:0] masked;
      input [7:0] data;
      input [7:0] wmask;
      begin
         masked = data & wmask;
      end
   endfunction

   reg [7:0] pin_dir_q;
   reg [7:0] dig_mask_q;
   reg [7:0] special_func_q;
   reg [7:0] error_cfg_q;
   reg [7:0] test_cal_q;
   reg [7:0] excitation_q;
   reg [7:0] clock_cfg_q;
   reg [7:0] selector_q;
   reg [7:0] test_switch_q;
   reg trig_q;
   reg [1:0] clr_q;
   reg [4:0] gp_meta_q;
   reg [4:0] gp_sync_q;
   reg pin4_prev_q;
   reg [6:0] ext_cnt_q;
   reg [31:0] int_cnt_q;
   reg int_clk_a_q;
   reg int_clk_b_q;
   reg [39:0] sched_cnt_q;
   reg [1:0] sched_mode_q;
   reg state_q;
   reg [12:0] run_cnt_q;
   reg [7:0] rdata_d;
   reg [39:0] period_d;
   reg [2:0] diag_d;
   wire [1:0] flags;
   wire ext_mode;
   wire sched_hit;
   wire cal_start;

   // ==========================================================
   // Register writes; trigger and flag clears are one-cycle pulses
   always @(posedge mclk) begin
      if (!rst_n) begin
         pin_dir_q <= `FCS_RST_PIN_DIR;
         dig_mask_q <= `FCS_RST_DIG_MASK;
         special_func_q <= `FCS_RST_SPECIAL_FUNC;
         error_cfg_q <= `FCS_RST_ERROR_CFG;
         test_cal_q <= `FCS_RST_TEST_CAL;
         excitation_q <= `FCS_RST_EXCITATION;
         clock_cfg_q <= `FCS_RST_CLOCK_CFG;
         selector_q <= `FCS_RST_SELECTOR;
         test_switch_q <= `FCS_RST_TEST_SWITCH;
         trig_q <= 1'b0;
         clr_q <= 2'h0;
      end else begin
         trig_q <= 1'b0;
         clr_q <= 2'h0;
         if (reg_wr) begin
            case (reg_addr)
               `FCS_OFS_PIN_DIR: pin_dir_q <= masked(reg_wdata, `FCS_WMASK_PIN_DIR);
               `FCS_OFS_DIG_MASK: dig_mask_q <= masked(reg_wdata, `FCS_WMASK_DIG_MASK);
               `FCS_OFS_SPECIAL_FUNC: begin
                  special_func_q <= masked(reg_wdata, `FCS_WMASK_SPECIAL_FUNC);
               end
               `FCS_OFS_ERROR_CFG: error_cfg_q <= masked(reg_wdata, `FCS_WMASK_ERROR_CFG);
               `FCS_OFS_TEST_CAL: test_cal_q <= masked(reg_wdata, `FCS_WMASK_TEST_CAL);
               `FCS_OFS_EXCITATION: begin
                  excitation_q <= masked(reg_wdata, `FCS_WMASK_EXCITATION);
               end
               `FCS_OFS_CAL_TRIGGER: trig_q <= reg_wdata[0];
               `FCS_OFS_STATUS: clr_q <= reg_wdata[1:0];
               `FCS_OFS_CLOCK_CFG: clock_cfg_q <= masked(reg_wdata, `FCS_WMASK_CLOCK_CFG);
               `FCS_OFS_SELECTOR: selector_q <= masked(reg_wdata, `FCS_WMASK_SELECTOR);
               `FCS_OFS_TEST_SWITCH: begin
                  test_switch_q <= masked(reg_wdata, `FCS_WMASK_TEST_SWITCH);
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // Read mux; unmapped and write-only offsets read zero
   always @* begin
      rdata_d = 8'h00;
      case (reg_addr)
         `FCS_OFS_PIN_DIR: rdata_d = pin_dir_q;
         `FCS_OFS_DIG_MASK: rdata_d = dig_mask_q;
         `FCS_OFS_SPECIAL_FUNC: rdata_d = special_func_q;
         `FCS_OFS_ERROR_CFG: rdata_d = error_cfg_q;
         `FCS_OFS_TEST_CAL: rdata_d = test_cal_q;
         `FCS_OFS_EXCITATION: rdata_d = excitation_q;
         `FCS_OFS_STATUS: rdata_d = {4'h0, ext_clk_mode_q, cal_busy_q, err_flags_q};
         `FCS_OFS_CLOCK_CFG: rdata_d = clock_cfg_q;
         `FCS_OFS_SELECTOR: rdata_d = selector_q;
         `FCS_OFS_TEST_SWITCH: rdata_d = test_switch_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else begin
         reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
      end
   end

   // ==========================================================
   // Error flag filters, one per checksum flag
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
         fcs_flag_filter u_filter (
            .mclk(mclk),
            .rst_n(rst_n),
            .err_cond(gi == 0 ? rom_checksum_fault : memmap_checksum_fault),
            .mask(dig_mask_q[gi]),
            .latch_dis(error_cfg_q[`FCS_EC_LATCH_DIS]),
            .delay_cyc(delay_of(error_cfg_q[3:0])),
            .clear(clr_q[gi]),
            .flag_q(flags[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Pin input synchroniser; first stage feeds only the second
   always @(posedge mclk) begin
      if (!rst_n) begin
         gp_meta_q <= 5'h00;
         gp_sync_q <= 5'h00;
      end else begin
         gp_meta_q <= gp_in;
         gp_sync_q <= gp_meta_q;
      end
   end

   // ==========================================================
   // External clock on pin 4: count edges, emit one tick per divide
   assign ext_mode = ~pin_dir_q[4] & special_func_q[`FCS_SF_EXT_CLK];

   always @(posedge mclk) begin
      if (!rst_n) begin
         pin4_prev_q <= 1'b0;
         ext_cnt_q <= 7'h00;
         ext_tick_q <= 1'b0;
         ext_clk_mode_q <= 1'b0;
      end else begin
         pin4_prev_q <= gp_sync_q[4];
         ext_clk_mode_q <= ext_mode;
         ext_tick_q <= 1'b0;
         if (!ext_mode) begin
            ext_cnt_q <= 7'h00;
         end else if (gp_sync_q[4] & ~pin4_prev_q) begin
            // Divide by 2^code; reset code 4 gives 16
            if (ext_cnt_q == ((7'h01 << clock_cfg_q[2:0]) - 7'h01)) begin
               ext_cnt_q <= 7'h00;
               ext_tick_q <= 1'b1;
            end else begin
               ext_cnt_q <= ext_cnt_q + 7'h01;
            end
         end
      end
   end

   // ==========================================================
   // Internal clocks for pin 4: 1 MHz and half of it
   always @(posedge mclk) begin
      if (!rst_n) begin
         int_cnt_q <= 32'h0;
         int_clk_a_q <= 1'b0;
         int_clk_b_q <= 1'b0;
      end else if (int_cnt_q == `FCS_INT_HALF_CYC - 32'h1) begin
         int_cnt_q <= 32'h0;
         int_clk_a_q <= ~int_clk_a_q;
         if (int_clk_a_q) begin
            int_clk_b_q <= ~int_clk_b_q;
         end
      end else begin
         int_cnt_q <= int_cnt_q + 32'h1;
      end
   end

   // ==========================================================
   // Calibration schedule timer; restarts when the interval changes
   always @* begin
      case (test_cal_q[5:4])
         2'h1: period_d = SCHED_P1_CYC;
         2'h2: period_d = SCHED_P2_CYC;
         2'h3: period_d = SCHED_P3_CYC;
         default: period_d = 40'h0;
      endcase
   end

   assign sched_hit = (test_cal_q[5:4] != 2'h0) && (sched_cnt_q >= period_d - 40'h1);
   // One-shot trigger only counts with the schedule off
   assign cal_start = sched_hit | (trig_q & (test_cal_q[5:4] == 2'h0));

   always @(posedge mclk) begin
      if (!rst_n) begin
         sched_cnt_q <= 40'h0;
         sched_mode_q <= 2'h0;
      end else begin
         sched_mode_q <= test_cal_q[5:4];
         if (test_cal_q[5:4] == 2'h0 || test_cal_q[5:4] != sched_mode_q || sched_hit) begin
            sched_cnt_q <= 40'h0;
         end else begin
            sched_cnt_q <= sched_cnt_q + 40'h1;
         end
      end
   end

   // ==========================================================
   // Calibration sequencer; a start while running is ignored
   always @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         run_cnt_q <= 13'h0;
         cal_busy_q <= 1'b0;
         cal_full_q <= 1'b0;
         inputs_connected_q <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cal_start) begin
                  state_q <= ST_RUN;
                  cal_full_q <= test_cal_q[`FCS_TC_CAL_FULL];
                  run_cnt_q <= test_cal_q[`FCS_TC_CAL_FULL] ?
                     `FCS_CAL_FULL_CYC - 13'h1 : `FCS_CAL_QUICK_CYC - 13'h1;
                  cal_busy_q <= 1'b1;
                  inputs_connected_q <= 1'b0;
               end
            end
            ST_RUN: begin
               if (run_cnt_q == 13'h0) begin
                  state_q <= ST_IDLE;
                  cal_busy_q <= 1'b0;
                  inputs_connected_q <= 1'b1;
               end else begin
                  run_cnt_q <= run_cnt_q - 13'h1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Diagnostic source decode; unlisted codes connect nothing
   always @* begin
      case (test_cal_q[3:0])
         4'h0: diag_d = `FCS_DIAG_AG_AG;
         4'h1: diag_d = `FCS_DIAG_DG_AG;
         4'h4: diag_d = `FCS_DIAG_AG_DG;
         4'h5: diag_d = `FCS_DIAG_DG_DG;
         4'ha: diag_d = `FCS_DIAG_POS20;
         4'hf: diag_d = `FCS_DIAG_NEG20;
         default: diag_d = `FCS_DIAG_NONE;
      endcase
   end

   // ==========================================================
   // Registered analog controls and pin drive
   always @(posedge mclk) begin
      if (!rst_n) begin
         err_flags_q <= 2'h0;
         scale_gain_q <= `FCS_GAIN_X1;
         diag_src_q <= `FCS_DIAG_NONE;
         diag_connect_q <= 1'b0;
         excitation_connect_q <= 1'b0;
         excitation_level_q <= 4'h0;
         gp_out_q <= 5'h00;
         gp_oe_q <= 5'h00;
      end else begin
         err_flags_q <= flags;
         // Lower bit sits beside the selector bits and dominates the upper one
         if (selector_q[`FCS_SEL_GAIN_LO]) begin
            scale_gain_q <= `FCS_GAIN_X1P375;
         end else if (test_cal_q[`FCS_TC_GAIN_UP]) begin
            scale_gain_q <= `FCS_GAIN_X1P25;
         end else begin
            scale_gain_q <= `FCS_GAIN_X1;
         end
         diag_src_q <= diag_d;
         diag_connect_q <= (&test_switch_q[1:0]) && (diag_d != `FCS_DIAG_NONE);
         excitation_connect_q <= excitation_q[`FCS_EX_CONNECT];
         excitation_level_q <= excitation_q[3:0];
         gp_oe_q <= pin_dir_q[4:0];
         gp_out_q[4] <= special_func_q[`FCS_SF_CLK_OUT] &
            (clock_cfg_q[`FCS_CLK_OUT_SEL] ? int_clk_b_q : int_clk_a_q);
         gp_out_q[3] <= special_func_q[`FCS_SF_FAULT_OUT] & (|flags);
         gp_out_q[2] <= special_func_q[`FCS_SF_BUSY_OUT] & cal_busy_q;
         gp_out_q[1:0] <= special_func_q[1:0] & selector_q[1:0];
      end
   end

endmodule
`default_nettype wire

// [sim/fcs_regs_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the register block
module fcs_regs_checker (
   input wire mclk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata_q,
   input wire rom_checksum_fault,
   input wire [4:0] gp_out_q,
   input wire [4:0] gp_oe_q,
   input wire [1:0] err_flags_q,
   input wire cal_busy_q,
   input wire inputs_connected_q
);
   reg [1:0] mask_q;
   reg [7:0] ecfg_q;
   reg [1:0] sched_q;
   reg [3:0] calm_q;
   wire cfg_wr;
   wire quiet;

   // Writes that disturb flags
   assign cfg_wr = reg_wr && (reg_addr == 8'h0b || reg_addr == 8'h0d || reg_addr == 8'h30);
   assign quiet = (calm_q == 4'h0) && !cfg_wr;

   // Shadow fields; a recent config write mutes the flag checks
   always @(posedge mclk) begin
      if (!rst_n) begin
         mask_q <= 2'h0;
         ecfg_q <= 8'h04;
         sched_q <= 2'h0;
         calm_q <= 4'h0;
      end else begin
         calm_q <= {calm_q[2:0], cfg_wr};
         if (reg_wr && reg_addr == 8'h0b) begin
            mask_q <= reg_wdata[1:0];
         end
         if (reg_wr && reg_addr == 8'h0d) begin
            ecfg_q <= reg_wdata & 8'h8f;
         end
         if (reg_wr && reg_addr == 8'h0e) begin
            sched_q <= reg_wdata[5:4];
         end
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   trig_read_zero_a: assert property (
      $past(reg_rd) && $past(reg_addr) == 8'h2a |-> reg_rdata_q == 8'h00)
      else $error("trigger register read back nonzero");
   pin_dir_a: assert property (
      $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h08
      |-> {3'h0, gp_oe_q} == ($past(reg_wdata, 2) & 8'h1f))
      else $error("pin enables differ from direction write");
   busy_isolate_a: assert property (cal_busy_q |-> !inputs_connected_q)
      else $error("inputs connected while calibrating");
   trig_start_a: assert property (
      reg_wr && reg_addr == 8'h2a && reg_wdata[0] && sched_q == 2'h0 && !cal_busy_q
      |-> ##3 cal_busy_q)
      else $error("trigger did not start calibration");
   busy_pin_a: assert property (gp_out_q[2] |-> cal_busy_q || $past(cal_busy_q))
      else $error("pin 2 high without busy");
   fault_pin_a: assert property (
      gp_out_q[3] |=> err_flags_q != 2'h0 || $past(err_flags_q) != 2'h0
      || $past(err_flags_q, 2) != 2'h0)
      else $error("pin 3 high without fault flag");
   mask_mm_a: assert property (mask_q[1] && $past(mask_q[1], 3) |-> !err_flags_q[1])
      else $error("masked memory map flag seen");
   mask_rom_a: assert property (mask_q[0] && $past(mask_q[0], 3) |-> !err_flags_q[0])
      else $error("masked rom flag seen");
   latch_hold_a: assert property (
      err_flags_q[0] && !ecfg_q[7] && quiet |=> err_flags_q[0])
      else $error("latched flag dropped without clear");
   delay_early_a: assert property (
      ecfg_q == 8'h82 && !mask_q[0] && quiet && $rose(rom_checksum_fault) && !err_flags_q[0]
      |=> !err_flags_q[0] [*2])
      else $error("flag tripped before persistence count");
   delay_trip_a: assert property (
      ecfg_q == 8'h82 && !mask_q[0] && quiet && $rose(rom_checksum_fault)
      ##1 rom_checksum_fault [*5] |-> err_flags_q[0])
      else $error("held fault did not trip flag");
endmodule

bind fcs_regs fcs_regs_checker u_chk (.*);
`default_nettype wire

// [sim/tb_fcs_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.vh"
`define CHK(nm, e, g) \
   begin \
      comparisons = comparisons + 1; \
      if ((g) !== (e)) begin \
         err_count = err_count + 1; \
         $display("unexpected %s expected %h seen %h", nm, (e), (g)); \
      end \
   end

module tb_fcs_regs;
   reg mclk, rst_n, reg_wr, reg_rd, memmap_checksum_fault, rom_checksum_fault;
   reg [7:0] reg_addr, reg_wdata;
   reg [4:0] gp_in;
   wire [7:0] reg_rdata_q;
   wire [4:0] gp_out_q, gp_oe_q;
   wire ext_clk_mode_q, ext_tick_q, cal_busy_q, cal_full_q, inputs_connected_q;
   wire [1:0] err_flags_q, scale_gain_q;
   wire [2:0] diag_src_q;
   wire diag_connect_q, excitation_connect_q;
   wire [3:0] excitation_level_q;
   integer err_count, comparisons;

   // Short schedule periods keep the run brief
   fcs_regs #(.SCHED_P1_CYC(40'd200), .SCHED_P2_CYC(40'd400), .SCHED_P3_CYC(40'd600)) uut (.*);

   // ==========================================================
   // Bus and helper tasks
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge mclk);
         reg_wr <= 1'b0;
      end
   endtask

   task rdchk(input [7:0] a, input [7:0] e);
      begin
         @(posedge mclk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1;
         `CHK("read data", e, reg_rdata_q);
      end
   endtask

   // Outputs trail a write
   task settle;
      begin
         repeat (4) @(posedge mclk);
         #1;
      end
   endtask

   task count_busy(input lvl, input integer lim, output integer n);
      begin
         n = 0;
         while (cal_busy_q === lvl && n < lim) begin
            @(posedge mclk);
            #1;
            n = n + 1;
         end
      end
   endtask

   task do_reset;
      begin
         @(posedge mclk);
         rst_n <= 1'b0;
         repeat (2) @(posedge mclk);
         rst_n <= 1'b1;
      end
   endtask

   task give_verdict;
      begin
         if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask

   // ==========================================================
   // Scenarios
   task t_regs;
      reg [71:0] ofs, rv, msk;
      integer i;
      begin
         ofs = 72'h08_0b_0c_0d_0e_0f_31_32_33;
         rv = 72'h00_00_00_04_00_00_04_00_00;
         msk = 72'h7f_03_3f_8f_ff_cf_0f_07_03;
         `CHK("connected after reset", 1'b1, inputs_connected_q);
         `CHK("diag after reset", 3'h7, diag_src_q);
         for (i = 0; i < 9; i = i + 1) begin
            rdchk(ofs[8*i +: 8], rv[8*i +: 8]);
            wr(ofs[8*i +: 8], 8'hff);
            rdchk(ofs[8*i +: 8], msk[8*i +: 8]);
         end
         wr(8'h40, 8'h5a);
         rdchk(8'h40, 8'h00);
         rdchk(8'h2a, 8'h00);
         do_reset;
      end
   endtask

   task t_pins;
      integer n, k;
      reg last;
      begin
         wr(8'h08, 8'h1f);
         settle;
         `CHK("pin enables", 5'h1f, gp_oe_q);
         wr(8'h0c, 8'h03);
         for (k = 1; k < 3; k = k + 1) begin
            wr(8'h32, k[7:0]);
            settle;
            `CHK("selector pins", k[1:0], gp_out_q[1:0]);
         end
         // Toggles over 800 cycles: 1 MHz gives 8, 500 kHz gives 4
         wr(8'h0c, 8'h20);
         for (k = 0; k < 2; k = k + 1) begin
            wr(8'h31, 8'h04 | (k[7:0] << 3));
            settle;
            n = 0;
            last = gp_out_q[4];
            repeat (800) begin
               @(posedge mclk);
               #1;
               n = n + (gp_out_q[4] !== last);
               last = gp_out_q[4];
            end
            `CHK("clock out toggles", 1'b1, n >= 7 - 4 * k && n <= 9 - 4 * k);
         end
         wr(8'h31, 8'h04);
         wr(8'h08, 8'h00);
         wr(8'h0c, 8'h10);
         settle;
         `CHK("external clock mode", 1'b1, ext_clk_mode_q);
         n = 0;
         for (k = 0; k < 340; k = k + 1) begin
            @(posedge mclk);
            gp_in[4] <= (k % 10) < 5 && k < 320; // steady, even duty
            #1;
            n = n + (ext_tick_q === 1'b1);
         end
         `CHK("ticks for 32 edges", 2, n);
      end
   endtask

   task t_flags;
      reg [31:0] codes, dly;
      integer k, d, base;
      begin
         wr(8'h08, 8'h08);
         wr(8'h0c, 8'h08);
         @(posedge mclk);
         rom_checksum_fault <= 1'b1;
         @(posedge mclk);
         rom_checksum_fault <= 1'b0;
         settle;
         `CHK("latched rom flag", 2'h1, err_flags_q);
         `CHK("fault pin", 1'b1, gp_out_q[3]);
         rdchk(8'h30, 8'h01);
         wr(8'h30, 8'h01);
         settle;
         `CHK("cleared flag", 2'h0, err_flags_q);
         for (k = 0; k < 2; k = k + 1) begin
            wr(8'h0b, 8'h01 << k);
            @(posedge mclk);
            rom_checksum_fault <= (k == 0);
            memmap_checksum_fault <= (k == 1);
            settle;
            `CHK("masked flags", 2'h0, err_flags_q);
            rom_checksum_fault <= 1'b0;
            memmap_checksum_fault <= 1'b0;
         end
         wr(8'h0b, 8'h00);
         wr(8'h30, 8'h03);
         // Trip time grows by the table step
         codes = 32'h80_88_89_8f;
         dly = {8'd0, 8'd8, 8'd12, 8'd127};
         base = 0;
         for (k = 3; k >= 0; k = k - 1) begin
            wr(8'h0d, codes[8*k +: 8]);
            @(posedge mclk);
            rom_checksum_fault <= 1'b1;
            d = 0;
            while (err_flags_q[0] !== 1'b1 && d < 300) begin
               @(posedge mclk);
               #1;
               d = d + 1;
            end
            base = (k == 3) ? d : base;
            `CHK("trip delay", base + dly[8*k +: 8], d);
            rom_checksum_fault <= 1'b0;
            settle;
            `CHK("transparent flag drops", 2'h0, err_flags_q);
         end
         wr(8'h0d, 8'h82);
         for (k = 0; k < 12; k = k + 1) begin
            @(posedge mclk);
            rom_checksum_fault <= (k % 3) != 2;
            #1;
            `CHK("brief faults filtered", 2'h0, err_flags_q);
         end
         @(posedge mclk);
         rom_checksum_fault <= 1'b1;
         repeat (8) @(posedge mclk);
         rom_checksum_fault <= 1'b0;
         #1;
         `CHK("held fault trips", 2'h1, err_flags_q);
         wr(8'h0d, 8'h04);
      end
   endtask

   task t_cal;
      integer k, n;
      begin
         wr(8'h08, 8'h04);
         wr(8'h0c, 8'h04);
         for (k = 0; k < 2; k = k + 1) begin
            wr(8'h0e, {1'b0, k[0], 6'h00});
            wr(8'h2a, 8'h01);
            repeat (2) @(posedge mclk);
            #1;
            `CHK("busy after trigger", 1'b1, cal_busy_q);
            `CHK("inputs released", 1'b0, inputs_connected_q);
            `CHK("busy on pin 2", 1'b1, gp_out_q[2]);
            `CHK("calibration type", k[0], cal_full_q);
            wr(8'h2a, 8'h01);
            count_busy(1'b1, 5000, n);
            n = n + 4;
            `CHK("busy length", 1'b1, n >= 992 + 3000 * k && n <= 1006 + 3000 * k);
            settle;
            `CHK("inputs back", 1'b1, inputs_connected_q);
         end
         // A trigger under a schedule is ignored; the period alone starts it
         for (k = 1; k < 4; k = k + 1) begin
            wr(8'h0e, {2'h0, k[1:0], 4'h0});
            wr(8'h2a, 8'h01);
            count_busy(1'b0, 900, n);
            `CHK("scheduled start", 1'b1, n >= 200 * k - 14 && n <= 200 * k + 10);
            wr(8'h0e, 8'h00);
            count_busy(1'b1, 5000, n);
         end
         count_busy(1'b0, 800, n);
         `CHK("schedule off", 800, n);
      end
   endtask

   task t_misc;
      reg [23:0] cv;
      reg [17:0] ev;
      integer k;
      begin
         wr(8'h0e, 8'h80);
         settle;
         `CHK("upper scale gain", `FCS_GAIN_X1P25, scale_gain_q);
         cv = 24'hfa5410;
         ev = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
         wr(8'h33, 8'h01);
         for (k = 0; k < 6; k = k + 1) begin
            wr(8'h0e, {4'h0, cv[4*k +: 4]});
            settle;
            `CHK("diag source", ev[3*k +: 3], diag_src_q);
            `CHK("one switch blocks", 1'b0, diag_connect_q);
         end
         wr(8'h33, 8'h03);
         settle;
         `CHK("both switches connect", 1'b1, diag_connect_q);
         `CHK("unity scale gain", `FCS_GAIN_X1, scale_gain_q);
         wr(8'h32, 8'h04);
         wr(8'h0f, 8'h4a);
         settle;
         `CHK("lower scale gain", `FCS_GAIN_X1P375, scale_gain_q);
         `CHK("excitation", 5'h1a, {excitation_connect_q, excitation_level_q});
      end
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      memmap_checksum_fault = 1'b0;
      rom_checksum_fault = 1'b0;
      gp_in = 5'h00;
      err_count = 0;
      comparisons = 0;
      do_reset;
      t_regs;
      t_pins;
      t_flags;
      t_cal;
      t_misc;
      give_verdict;
   end

   initial begin
      repeat (60000) @(posedge mclk);
      err_count = err_count + 1;
      give_verdict;
   end
endmodule
`undef CHK
`default_nettype wire
